// ---- inc/aairq_consts.vh ----
/*
  Constants of the interrupt configuration block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 200 MHz mclk.
*/
`ifndef AAIRQ_CONSTS_VH
`define AAIRQ_CONSTS_VH

`define AAIRQ_ADDR_CFG        8'h32
`define AAIRQ_ADDR_MASK       8'h33
`define AAIRQ_ADDR_LATCH      8'h36

`define AAIRQ_CFG_POL_BIT     7
`define AAIRQ_CFG_EVT_HI      6
`define AAIRQ_CFG_EVT_LO      5
`define AAIRQ_CFG_FILT_BIT    2
`define AAIRQ_CFG_WMASK       8'hE4
`define AAIRQ_CFG_RESET       8'h00
`define AAIRQ_MASK_RESET      8'hFF

`define AAIRQ_SRC_CLKERR      7
`define AAIRQ_SRC_PLLLOCK     6
`define AAIRQ_SRC_SATURATE    5
`define AAIRQ_SRC_VADUP       4
`define AAIRQ_SRC_VADDOWN     3
`define AAIRQ_SRC_LO          3
`define AAIRQ_NUM_SRC         5

`define AAIRQ_STYLE_LEVEL     2'h0
`define AAIRQ_STYLE_REPEAT    2'h2
`define AAIRQ_STYLE_ONCE      2'h3

`define AAIRQ_CLK_MHZ         200
`define AAIRQ_PULSE_MS        2
`define AAIRQ_PERIOD_MS       4
// 2 ms and 4 ms at 200 MHz, sized to the 24-bit timer
`define AAIRQ_PULSE_CYCLES    24'h061A80
`define AAIRQ_PERIOD_CYCLES   24'h0C3500

`endif

// ---- src/aairq_event_sync.v ----
/*
  Two-flop synchroniser and rising-edge detector for the event inputs.
  Assumes event sources are levels from outside the mclk domain.
*/
`timescale 1ns/1ps
module aairq_event_sync #(
  parameter WIDTH = 5
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] eventIn,
  output reg  [WIDTH-1:0] eventRise
);
  reg [WIDTH-1:0] syncA;
  reg [WIDTH-1:0] syncB;
  reg [WIDTH-1:0] syncPrev;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          syncA[i]     <= 1'b0;
          syncB[i]     <= 1'b0;
          syncPrev[i]  <= 1'b0;
          eventRise[i] <= 1'b0;
        end else begin
          syncA[i]     <= eventIn[i];
          syncB[i]     <= syncA[i];
          syncPrev[i]  <= syncB[i];
          eventRise[i] <= syncB[i] & ~syncPrev[i];
        end
      end
    end
  endgenerate
endmodule // aairq_event_sync

// ---- src/aairq_ctrl.v ----
/*
  Interrupt configuration, masking and latched-flag readback of a
  two-channel audio converter, with the interrupt output generator.
  Assumes a simple synchronous register port (one-cycle write strobe,
  read strobe with combinational-free registered data) from the
  control-bus slave, and event inputs from other clock domains.
*/
// What this block does
// - Polarity bit 7: 0 low, 1 high
// - Style 0: assert while unmasked event pending
// - Style 2: 2 ms on per 4 ms
// - Style 3: 2 ms pulse on event; a new event restarts the pulse
// - Filter bit 2 hides masked flags on readback
// - Config resets zero; reserved bits read zero
// - Mask 1 suppresses source; masks reset 0xFF
// - Mask bit 7: serial port clock error
// - Mask bit 6: PLL lock
// - Mask bit 5: mixing saturation alert
// - Mask bit 4: activity power-up detect
// - Mask bit 3: activity power-down detect
// - Flags set per source, clear on read
// - Flag bits share mask bit positions
`timescale 1ns/1ps
`include "aairq_consts.vh"
module aairq_ctrl (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  output reg  [7:0] regRdata,
  input  wire       serialAudioPortClkErr,
  input  wire       pllLock,
  input  wire       mixSaturation,
  input  wire       voiceActivityDetectorUp,
  input  wire       voiceActivityDetectorDown,
  output reg        irqLine
);
  localparam [23:0] PULSE_CYC  = `AAIRQ_PULSE_CYCLES;
  localparam [23:0] PERIOD_CYC = `AAIRQ_PERIOD_CYCLES;

  reg  [7:0] intConfig;
  reg  [7:0] irqSourceMasks;
  reg  [7:0] latchedEventFlags;
  reg  [23:0] pulseCount;
  reg        pulseActive;
  reg  [23:0] next_pulseCount;
  reg        next_pulseActive;
  reg        assertNow;
  reg  [7:0] next_flags;
  reg  [7:0] readValue;

  wire [`AAIRQ_NUM_SRC-1:0] eventRise;
  wire [7:0] eventVec;
  wire [7:0] unmaskedPending;
  wire [7:0] unmaskedEvent;
  wire       irqPolaritySel;
  wire [1:0] irqStyle;
  wire       latchedViewFilter;
  wire       readLatch;
  wire       cfgWrite;
  wire       maskWrite;

  aairq_event_sync #(
    .WIDTH (`AAIRQ_NUM_SRC)
  ) uSync (
    .mclk      (mclk),
    .resetn    (resetn),
    .eventIn   ({serialAudioPortClkErr, pllLock, mixSaturation,
                 voiceActivityDetectorUp, voiceActivityDetectorDown}),
    .eventRise (eventRise)
  );

  // Sources in bits 7..3, reserved positions never see events
  assign eventVec          = {eventRise, 3'h0};
  assign irqPolaritySel    = intConfig[`AAIRQ_CFG_POL_BIT];
  assign irqStyle          = intConfig[`AAIRQ_CFG_EVT_HI:`AAIRQ_CFG_EVT_LO];
  assign latchedViewFilter = intConfig[`AAIRQ_CFG_FILT_BIT];
  // Mask bits 7..3 gate clock error, PLL, saturation, activity up/down
  assign unmaskedPending   = latchedEventFlags & ~irqSourceMasks;
  assign unmaskedEvent     = eventVec & ~irqSourceMasks;
  assign readLatch         = regRead && (regAddr == `AAIRQ_ADDR_LATCH);
  assign cfgWrite          = regWrite && (regAddr == `AAIRQ_ADDR_CFG);
  assign maskWrite         = regWrite && (regAddr == `AAIRQ_ADDR_MASK);

  // Reserved config bits are not writable, so they always read zero
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      intConfig <= `AAIRQ_CFG_RESET;
    end else if (cfgWrite) begin
      intConfig <= regWdata & `AAIRQ_CFG_WMASK;
    end
  end

  // Bits 2..0 stored as written; software keeps them at one
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqSourceMasks <= `AAIRQ_MASK_RESET;
    end else if (maskWrite) begin
      irqSourceMasks <= regWdata;
    end
  end

  // Read clears the flags; an event in the same cycle survives the clear
  always @* begin
    next_flags = latchedEventFlags;
    if (readLatch) begin
      next_flags = 8'h00;
    end
    next_flags = next_flags | eventVec;
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latchedEventFlags <= 8'h00;
    end else begin
      latchedEventFlags <= next_flags;
    end
  end

  always @* begin
    readValue = 8'h00;
    case (regAddr)
      `AAIRQ_ADDR_CFG:   readValue = intConfig;
      `AAIRQ_ADDR_MASK:  readValue = irqSourceMasks;
      `AAIRQ_ADDR_LATCH: readValue = latchedViewFilter ? unmaskedPending
                                                       : latchedEventFlags;
      default:           readValue = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= readValue;
    end
  end

  // Timer: free-running 4 ms frame for style 2, one-shot 2 ms for style 3
  always @* begin
    next_pulseCount  = pulseCount;
    next_pulseActive = pulseActive;
    case (irqStyle)
      `AAIRQ_STYLE_REPEAT: begin
        next_pulseActive = 1'b0;
        if (pulseCount >= PERIOD_CYC - 24'h000001) begin
          next_pulseCount = 24'h000000;
        end else begin
          next_pulseCount = pulseCount + 24'h000001;
        end
      end
      `AAIRQ_STYLE_ONCE: begin
        // A new event restarts the pulse rather than queueing another
        if (|unmaskedEvent) begin
          next_pulseActive = 1'b1;
          next_pulseCount  = 24'h000000;
        end else if (pulseActive) begin
          if (pulseCount >= PULSE_CYC - 24'h000001) begin
            next_pulseActive = 1'b0;
            next_pulseCount  = 24'h000000;
          end else begin
            next_pulseCount = pulseCount + 24'h000001;
          end
        end
      end
      default: begin
        // Style 1 is never programmed; it behaves like style 0
        next_pulseActive = 1'b0;
        next_pulseCount  = 24'h000000;
      end
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulseCount  <= 24'h000000;
      pulseActive <= 1'b0;
    end else begin
      pulseCount  <= next_pulseCount;
      pulseActive <= next_pulseActive;
    end
  end

  always @* begin
    assertNow = 1'b0;
    case (irqStyle)
      `AAIRQ_STYLE_REPEAT: assertNow = (|unmaskedPending) &&
                                       (pulseCount < PULSE_CYC);
      `AAIRQ_STYLE_ONCE:   assertNow = pulseActive;
      default:             assertNow = |unmaskedPending;
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqLine <= 1'b1;
    end else begin
      irqLine <= irqPolaritySel ? assertNow : ~assertNow;
    end
  end
endmodule // aairq_ctrl

// ---- testbench/aairq_ctrl_assertions.sv ----
/* Port-level checker for aairq_ctrl.
   Assumes single mclk domain; config shadowed from bus writes only. */
`timescale 1ns/1ps
module aairq_ctrl_assertions (
  input wire       mclk,
  input wire       resetn,
  input wire       regWrite,
  input wire       regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire       serialAudioPortClkErr,
  input wire       pllLock,
  input wire       irqLine
);
  logic       pol;
  logic       filt;
  logic [1:0] style;
  logic [4:0] mask;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {pol, style} <= 3'h0;
      filt <= 1'b0;
      mask <= 5'h1F;
    end else if (regWrite && regAddr == 8'h32) begin
      {pol, style} <= regWdata[7:5];
      filt <= regWdata[2];
    end else if (regWrite && regAddr == 8'h33) begin
      mask <= regWdata[7:3];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  cfg_resv_zero_a: assert property (regRead && regAddr == 8'h32 |=>
    (regRdata & 8'h1B) == 8'h00) else $error("config reserved bits nonzero");
  flag_resv_zero_a: assert property (regRead && regAddr == 8'h36 |=>
    regRdata[2:0] == 3'h0) else $error("flag reserved bits nonzero");
  flag_filter_a: assert property (regRead && regAddr == 8'h36 && filt |=>
    (regRdata[7:3] & $past(mask)) == 5'h00) else $error("masked flag visible");
  mask_readback_a: assert property (regWrite && regAddr == 8'h33 ##1 regRead &&
    regAddr == 8'h33 |=> regRdata == $past(regWdata, 2)) else $error("mask readback");
  masked_quiet_a: assert property (style == 2'h0 && mask == 5'h1F ##1 style == 2'h0 &&
    mask == 5'h1F && $stable(pol) |-> irqLine != pol) else $error("masked irq asserted");
  level_assert_a: assert property (style == 2'h0 && !mask[4] &&
    $rose(serialAudioPortClkErr) |-> ##[3:7] irqLine == pol) else $error("level irq late");
  once_pulse_a: assert property (style == 2'h3 && !mask[3] && $rose(pllLock)
    |-> ##[3:7] irqLine == pol) else $error("pulse irq late");
  once_hold_a: assert property (style == 2'h3 && $rose(irqLine == pol)
    |=> irqLine == pol [*8]) else $error("pulse irq too short");
  cover property (regRead && regAddr == 8'h36 && filt);
  cover property (style == 2'h3 && $rose(irqLine == pol));
  cover property (style == 2'h0 && pol && irqLine);
endmodule // aairq_ctrl_assertions

bind aairq_ctrl aairq_ctrl_assertions u_chk (.mclk(mclk), .resetn(resetn),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .serialAudioPortClkErr(serialAudioPortClkErr),
  .pllLock(pllLock), .irqLine(irqLine));

// ---- testbench/aairq_host_model.sv ----
/* Host-side view of the interrupt pin.
   Assumes polSel mirrors the polarity the host programmed. */
`timescale 1ns/1ps
module aairq_host_model (
  input  wire irqLine,
  input  wire polSel,
  output wire active
);
  // Pin counts as asserted only at the programmed level
  assign active = (irqLine === polSel);
endmodule // aairq_host_model

// ---- testbench/test_audio_adc_irq_ctrl.sv ----
/* Self-checking bench for aairq_ctrl with a reference model of config,
   masks and flags. Assumes 200 MHz mclk, event levels driven directly. */
`timescale 1ns/1ps
module test_audio_adc_irq_ctrl;
  logic       mclk = 0, resetn = 0, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
  logic [4:0] ev = 5'h00;
  wire  [7:0] regRdata;
  wire        irqLine, hostActive;
  int         bad_count = 0, n_checks = 0, seed = 32'h2bb9cd56;
  int         cfg = 0, mask = 8'hFF, flags = 0;
  aairq_ctrl u_dut (.mclk(mclk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .serialAudioPortClkErr(ev[4]), .pllLock(ev[3]), .mixSaturation(ev[2]),
    .voiceActivityDetectorUp(ev[1]), .voiceActivityDetectorDown(ev[0]), .irqLine(irqLine));
  aairq_host_model u_host (.irqLine(irqLine), .polSel(cfg[7]), .active(hostActive));
  initial forever #2.5 mclk = ~mclk;
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regWrite = 1;
    regAddr = a;
    regWdata = d;
    tick(1);
    regWrite = 0;
    if (a == 8'h32) cfg = d & 8'hE4;
    if (a == 8'h33) mask = d;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a);
    int exp;
    exp = 0;
    if (a == 8'h32) exp = cfg;
    if (a == 8'h33) exp = mask;
    if (a == 8'h36) exp = cfg[2] ? flags & ~mask : flags;
    regRead = 1;
    regAddr = a;
    tick(1);
    regRead = 0;
    if (a == 8'h36) flags = 0;
    chk("regRdata", regRdata, exp[7:0]);
    tick(1);
  endtask
  task automatic irq_chk(logic act);
    chk("irqLine", {7'h00, irqLine}, {7'h00, act ? cfg[7] : ~cfg[7]});
    chk("hostActive", {7'h00, hostActive}, {7'h00, act});
  endtask
  // Leaves the input low long enough for the next rise to be seen
  task automatic fire(int i);
    ev[i] = 1;
    tick(3);
    ev[i] = 0;
    flags |= 8 << i;
    tick(6);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    final_report;
  end
  initial begin
    tick(8);
    resetn = 1;
    tick(1);
    irq_chk(0);
    rd(8'h32);
    rd(8'h33);
    rd({1'b1, 7'($random(seed))});
    wr(8'h32, 8'($random(seed)) & 8'h9F);
    rd(8'h32);
    for (int i = 0; i < 5; i++) begin
      wr(8'h32, {i[0], 4'h0, i[1], 2'h0});
      wr(8'h33, ~(8'h08 << i));
      rd(8'h33);
      fire((i + 1) % 5);
      irq_chk(0);
      fire(i);
      irq_chk(1);
      rd(8'h36);
      tick(1);
      irq_chk(0);
    end
    wr(8'h33, 8'h07);
    wr(8'h32, 8'h60);
    fire(3);
    irq_chk(1);
    rd(8'h36);
    tick(200);
    irq_chk(1);
    wr(8'h32, 8'h40);
    fire(4);
    irq_chk(1);
    rd(8'h36);
    tick(1);
    irq_chk(0);
    resetn = 0;
    cfg = 0;
    mask = 8'hFF;
    flags = 0;
    tick(2);
    irq_chk(0);
    resetn = 1;
    tick(1);
    rd(8'h32);
    rd(8'h33);
    final_report;
  end
endmodule // test_audio_adc_irq_ctrl
